/* design/pdl_defines.svh */
// offsets, field positions and reset values of the peripheral disable/lock register
`ifndef PDL_DEFINES_SVH
`define PDL_DEFINES_SVH

`define PDL_ADDR_W 8
`define PDL_DATA_W 8

`define PDL_OFF_CTRL 8'h22
`define PDL_OFF_STATUS 8'h2F

`define PDL_CTRL_RESET 8'h00
`define PDL_CTRL_WMASK 8'hEB

`define PDL_BIT_WP 0
`define PDL_BIT_LOCK 1
`define PDL_BIT_RSVD2 2
`define PDL_BIT_FLOPPY 3
`define PDL_BIT_RSVD4 4
`define PDL_BIT_SER2 5
`define PDL_BIT_SER1 6
`define PDL_BIT_PRINTER 7

`define PDL_LOCK_CFG_HW 2'h1

`define PDL_ST_WP 0
`define PDL_ST_WRITABLE 1
`define PDL_ST_FLOPPY_EN 2
`define PDL_ST_SER2_EN 3
`define PDL_ST_SER1_EN 4
`define PDL_ST_PRINTER_EN 5
`define PDL_ST_LOCKED 6
`define PDL_ST_PIN 7

`define PDL_N_PERIPH 4

`endif

/* design/pdl_pkg.sv */
// types shared by the peripheral disable/lock register files
`default_nettype none

package pdl_pkg;

	typedef logic [7:0] pdl_byte_t;

	typedef enum {
		PDL_ACC_IDLE,
		PDL_ACC_WRITE,
		PDL_ACC_READ
	} pdl_access_t;

	typedef enum {
		PDL_PER_FLOPPY,
		PDL_PER_SER2,
		PDL_PER_SER1,
		PDL_PER_PRINTER
	} pdl_periph_t;

endpackage : pdl_pkg

`default_nettype wire

/* design/pdl_write_gate.sv */
// decides whether the control register may take a write
`include "pdl_defines.svh"
`default_nettype none

module pdl_write_gate (
	input wire logic [1:0] lock_cfg,
	input wire logic lock_pin,
	input wire logic lock_bit,
	output logic writable
);

	logic hw_locked;

	always_comb begin
		// hardware lock only when the pin is configured for it and held high
		hw_locked = (lock_cfg == `PDL_LOCK_CFG_HW) && lock_pin;
		writable = !lock_bit && !hw_locked;
	end

endmodule : pdl_write_gate

`default_nettype wire

/* design/pdl_periph_gate.sv */
// combines activate bits with overrides and gates host accesses
`default_nettype none

module pdl_periph_gate #(
	parameter int N = 4
) (
	input wire logic [N-1:0] activate,
	input wire logic [N-1:0] disable_ovr,
	input wire logic [N-1:0] lpc_sel,
	input wire logic [N-1:0] smb_sel,
	output logic [N-1:0] enabled,
	output logic [N-1:0] lpc_sel_out,
	output logic [N-1:0] smb_sel_out
);

	if (N < 1) begin : g_check
		$error("pdl_periph_gate needs at least one peripheral");
	end

	always_comb begin
		enabled = activate & ~disable_ovr;
		// a disabled peripheral never sees a decode hit from either host path
		lpc_sel_out = lpc_sel & enabled;
		smb_sel_out = smb_sel & enabled;
	end

endmodule : pdl_periph_gate

`default_nettype wire

/* design/pdl_top.sv */
// peripheral disable and lock control register with write-protect combining
//
// Functional notes
// R1 - write accepted only if unlocked and hardware lock pin not asserting
// R2 - register read-only when lock pin configured and high, or lock bit set
// R3 - bit 0 set forces floppy write protection over every other source
// R4 - write-protect output is OR of bit 0, drive pin, forced per select
// R5 - setting lock bit freezes all bits until power-on or bus reset
// R6 - lock bit clears only on power-on reset or host bus reset
// R7 - bit 2 reserved, always reads zero
// R8 - bit 3 set disables floppy controller over its activate bit
// R9 - bit 5 set disables second serial port over its activate bit
// R10 - bit 6 set disables first serial port over its activate bit
// R11 - bit 7 set disables printer port over its activate bit
// R12 - disabled peripheral ignores accesses from both host interfaces
// R13 - bit 4 reserved, no effect, reads zero
`include "pdl_defines.svh"
`default_nettype none

module pdl_top #(
	parameter int N_PERIPH = `PDL_N_PERIPH
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic HOST_RESET,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [1:0] HW_LOCK_CFG,
	input wire logic HW_LOCK_PIN,
	input wire logic WRITE_PROTECT_N,
	input wire logic DRIVE_SELECT0_N,
	input wire logic DRIVE_SELECT1_N,
	input wire logic FORCE_WRITE_PROTECT,
	output logic FLOPPY_WRITE_PROTECT_N,
	output logic FLOPPY_STATUS_A_WP,
	input wire logic [N_PERIPH-1:0] ACTIVATE,
	output logic [N_PERIPH-1:0] PERIPH_ENABLE,
	input wire logic [N_PERIPH-1:0] LPC_SEL,
	input wire logic [N_PERIPH-1:0] SMB_SEL,
	output logic [N_PERIPH-1:0] LPC_SEL_GATED,
	output logic [N_PERIPH-1:0] SMB_SEL_GATED
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (N_PERIPH != `PDL_N_PERIPH) begin : g_check
		$error("pdl_top serves exactly four peripherals");
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic pdl_pkg::pdl_access_t decode_access(
		input logic wr,
		input logic rd
	);
		pdl_pkg::pdl_access_t acc;
		acc = pdl_pkg::PDL_ACC_IDLE;
		if (wr) begin
			acc = pdl_pkg::PDL_ACC_WRITE;
		end else if (rd) begin
			acc = pdl_pkg::PDL_ACC_READ;
		end
		return acc;
	endfunction : decode_access

	function automatic pdl_pkg::pdl_byte_t read_view(
		input pdl_pkg::pdl_byte_t stored
	);
		// reserved bits never reach software
		return stored & `PDL_CTRL_WMASK; // R7 R13
	endfunction : read_view

	////////////////////////////////////////////////////////////////////////////
	// declarations

	pdl_pkg::pdl_access_t access;
	pdl_pkg::pdl_byte_t ctrl_reg;
	pdl_pkg::pdl_byte_t ctrl_next;
	pdl_pkg::pdl_byte_t rdata_reg;
	pdl_pkg::pdl_byte_t rdata_next;
	pdl_pkg::pdl_byte_t status_view;
	logic any_reset;
	logic hit_ctrl;
	logic hit_status;
	logic writable;
	logic lock_bit;
	logic drive_wp_active;
	logic ds0_active;
	logic ds1_active;
	logic wp_active;
	logic wp_reg;
	logic wp_next;
	logic [N_PERIPH-1:0] disable_ovr;
	logic [N_PERIPH-1:0] enabled_comb;
	logic [N_PERIPH-1:0] enable_reg;
	logic [N_PERIPH-1:0] enable_next;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	always_comb begin
		// power-on and host bus reset act alike on this register
		any_reset = RESET || HOST_RESET; // R6
		access = decode_access(WR, RD);
		hit_ctrl = (ADDR == `PDL_OFF_CTRL);
		hit_status = (ADDR == `PDL_OFF_STATUS);
		lock_bit = ctrl_reg[`PDL_BIT_LOCK];
	end

	////////////////////////////////////////////////////////////////////////////
	// write permission

	pdl_write_gate u_write_gate (
		.lock_cfg(HW_LOCK_CFG),
		.lock_pin(HW_LOCK_PIN),
		.lock_bit(lock_bit),
		.writable(writable)
	);

	////////////////////////////////////////////////////////////////////////////
	// control register

	always_comb begin
		ctrl_next = ctrl_reg;
		case (access)
			pdl_pkg::PDL_ACC_WRITE: begin
				// a refused write is dropped silently, no error is flagged
				if (hit_ctrl && writable) begin // R1 R2 R5
					ctrl_next = WDATA & `PDL_CTRL_WMASK; // R7 R13
				end
			end
			pdl_pkg::PDL_ACC_READ: begin
				ctrl_next = ctrl_reg;
			end
			pdl_pkg::PDL_ACC_IDLE: begin
				ctrl_next = ctrl_reg;
			end
			default: begin
				ctrl_next = ctrl_reg;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (any_reset) begin
			ctrl_reg <= `PDL_CTRL_RESET; // R6
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status view

	always_comb begin
		status_view = '0;
		status_view[`PDL_ST_WP] = wp_reg;
		status_view[`PDL_ST_WRITABLE] = writable;
		status_view[`PDL_ST_FLOPPY_EN] = enable_reg[pdl_pkg::PDL_PER_FLOPPY];
		status_view[`PDL_ST_SER2_EN] = enable_reg[pdl_pkg::PDL_PER_SER2];
		status_view[`PDL_ST_SER1_EN] = enable_reg[pdl_pkg::PDL_PER_SER1];
		status_view[`PDL_ST_PRINTER_EN] = enable_reg[pdl_pkg::PDL_PER_PRINTER];
		status_view[`PDL_ST_LOCKED] = lock_bit;
		status_view[`PDL_ST_PIN] = HW_LOCK_PIN;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	always_comb begin
		rdata_next = '0;
		case (access)
			pdl_pkg::PDL_ACC_READ: begin
				if (hit_ctrl) begin
					rdata_next = read_view(ctrl_reg); // R7 R13
				end else if (hit_status) begin
					rdata_next = status_view;
				end else begin
					rdata_next = '0;
				end
			end
			pdl_pkg::PDL_ACC_WRITE: begin
				rdata_next = '0;
			end
			pdl_pkg::PDL_ACC_IDLE: begin
				rdata_next = '0;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (any_reset) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// floppy write protect

	always_comb begin
		drive_wp_active = !WRITE_PROTECT_N;
		ds0_active = !DRIVE_SELECT0_N;
		ds1_active = !DRIVE_SELECT1_N;
		// bit 0 wins over the pin and the forced option
		wp_active = ctrl_reg[`PDL_BIT_WP] // R3 R4
			|| drive_wp_active
			|| (ds0_active && FORCE_WRITE_PROTECT)
			|| (ds1_active && FORCE_WRITE_PROTECT);
		wp_next = wp_active;
	end

	always_ff @(posedge CLOCK) begin
		if (any_reset) begin
			wp_reg <= 1'b0;
		end else begin
			wp_reg <= wp_next;
		end
	end

	// registered, so the pin reaches the core one cycle late
	assign FLOPPY_WRITE_PROTECT_N = !wp_reg; // R4
	assign FLOPPY_STATUS_A_WP = wp_reg; // R4

	////////////////////////////////////////////////////////////////////////////
	// peripheral overrides

	always_comb begin
		disable_ovr = '0;
		disable_ovr[pdl_pkg::PDL_PER_FLOPPY] = ctrl_reg[`PDL_BIT_FLOPPY]; // R8
		disable_ovr[pdl_pkg::PDL_PER_SER2] = ctrl_reg[`PDL_BIT_SER2]; // R9
		disable_ovr[pdl_pkg::PDL_PER_SER1] = ctrl_reg[`PDL_BIT_SER1]; // R10
		disable_ovr[pdl_pkg::PDL_PER_PRINTER] = ctrl_reg[`PDL_BIT_PRINTER]; // R11
	end

	// access gating stays combinational so a decode hit is never delayed
	pdl_periph_gate #(
		.N(N_PERIPH)
	) u_periph_gate (
		.activate(ACTIVATE),
		.disable_ovr(disable_ovr),
		.lpc_sel(LPC_SEL),
		.smb_sel(SMB_SEL),
		.enabled(enabled_comb),
		.lpc_sel_out(LPC_SEL_GATED), // R12
		.smb_sel_out(SMB_SEL_GATED) // R12
	);

	always_comb begin
		enable_next = enabled_comb; // R8 R9 R10 R11
	end

	always_ff @(posedge CLOCK) begin
		if (any_reset) begin
			enable_reg <= '0;
		end else begin
			enable_reg <= enable_next;
		end
	end

	assign PERIPH_ENABLE = enable_reg;

endmodule : pdl_top

`default_nettype wire

/* sim/pdl_top_chk.sv */
// port assertions for the disable/lock register
`default_nettype none
module pdl_top_chk #(
	parameter int N_PERIPH = 4
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic HOST_RESET,
	input wire logic [7:0] ADDR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic WRITE_PROTECT_N,
	input wire logic DRIVE_SELECT0_N,
	input wire logic DRIVE_SELECT1_N,
	input wire logic FORCE_WRITE_PROTECT,
	input wire logic FLOPPY_WRITE_PROTECT_N,
	input wire logic FLOPPY_STATUS_A_WP,
	input wire logic [N_PERIPH-1:0] ACTIVATE,
	input wire logic [N_PERIPH-1:0] PERIPH_ENABLE,
	input wire logic [N_PERIPH-1:0] LPC_SEL,
	input wire logic [N_PERIPH-1:0] SMB_SEL,
	input wire logic [N_PERIPH-1:0] LPC_SEL_GATED,
	input wire logic [N_PERIPH-1:0] SMB_SEL_GATED
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET || HOST_RESET);
	wire logic rst = RESET || HOST_RESET;
	wire logic rd22 = RD && ADDR == 8'h22;
	wire logic drive_sel = !DRIVE_SELECT0_N || !DRIVE_SELECT1_N;
	wire logic src = !WRITE_PROTECT_N || (FORCE_WRITE_PROTECT && drive_sel);
	sequence s_lock_rd;
		rd22 ##1 RDATA[1];
	endsequence
	property p_lock;
		s_lock_rd ##3 rd22 |=> RDATA == $past(RDATA, 4);
	endproperty
	a_lock: assert property (p_lock) else $error("locked register changed");
	property p_wp_pol;
		FLOPPY_STATUS_A_WP != FLOPPY_WRITE_PROTECT_N;
	endproperty
	a_wp_pol: assert property (p_wp_pol) else $error("protect outputs disagree");
	property p_wp_src;
		!$past(rst) && $past(src) |-> FLOPPY_STATUS_A_WP;
	endproperty
	a_wp_src: assert property (p_wp_src) else $error("protect source lost");
	property p_rsvd;
		$past(rd22) |-> RDATA[2] == 1'b0 && RDATA[4] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_rd_idle;
		!$past(RD) |-> RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_lpc;
		(LPC_SEL_GATED & ~(LPC_SEL & ACTIVATE)) == 0;
	endproperty
	a_lpc: assert property (p_lpc) else $error("lpc select leaks");
	property p_smb;
		(SMB_SEL_GATED & ~(SMB_SEL & ACTIVATE)) == 0;
	endproperty
	a_smb: assert property (p_smb) else $error("smbus select leaks");
	// registered enables must match the gating seen one cycle earlier
	property p_sel_en;
		!$past(rst) |-> $past(LPC_SEL_GATED) == ($past(LPC_SEL) & PERIPH_ENABLE);
	endproperty
	a_sel_en: assert property (p_sel_en) else $error("gated select and enable disagree");
	property p_en;
		(PERIPH_ENABLE & ~$past(ACTIVATE)) == 0;
	endproperty
	a_en: assert property (p_en) else $error("enable without activate");
endmodule : pdl_top_chk
bind pdl_top pdl_top_chk #(.N_PERIPH(N_PERIPH)) chk_u (.CLOCK, .RESET, .HOST_RESET, .ADDR,
	.RD, .RDATA, .WRITE_PROTECT_N, .DRIVE_SELECT0_N, .DRIVE_SELECT1_N, .FORCE_WRITE_PROTECT,
	.FLOPPY_WRITE_PROTECT_N, .FLOPPY_STATUS_A_WP, .ACTIVATE, .PERIPH_ENABLE, .LPC_SEL,
	.SMB_SEL, .LPC_SEL_GATED, .SMB_SEL_GATED);
`default_nettype wire

/* sim/pdl_host_model.sv */
// host side bus master of the register port
`default_nettype none
module pdl_host_model (
	input wire logic clk,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// stale data must not look valid
		wdata <= ~d;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : read
endmodule : pdl_host_model
`default_nettype wire

/* sim/test_peripheral_disable_lock_register.sv */
// self-checking bench for the disable/lock register
`default_nettype none
module test_peripheral_disable_lock_register;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, hrst = 1'b0, wr, rd, fwp_n, wpa;
	logic pin = 1'b0, wp_n = 1'b1, ds0_n = 1'b1, ds1_n = 1'b1, fwp = 1'b0;
	logic [7:0] addr, wdata, rdata, v;
	logic [1:0] cfg = 2'h0;
	logic [3:0] act = 4'hF, lsel = 4'hF, ssel = 4'hF, pe, lg, sg;
	logic [7:0] ob [4] = '{8'h08, 8'h20, 8'h40, 8'h80};
	int err_total = 0, n_compared = 0, cyc = 0;
	pdl_top dut_u (.CLOCK(clk), .RESET(rst), .HOST_RESET(hrst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .HW_LOCK_CFG(cfg), .HW_LOCK_PIN(pin),
		.WRITE_PROTECT_N(wp_n), .DRIVE_SELECT0_N(ds0_n), .DRIVE_SELECT1_N(ds1_n),
		.FORCE_WRITE_PROTECT(fwp), .FLOPPY_WRITE_PROTECT_N(fwp_n), .FLOPPY_STATUS_A_WP(wpa),
		.ACTIVATE(act), .PERIPH_ENABLE(pe), .LPC_SEL(lsel), .SMB_SEL(ssel),
		.LPC_SEL_GATED(lg), .SMB_SEL_GATED(sg));
	pdl_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	always #12.5 clk = ~clk;
	////////////////////////////////
	task automatic cmp(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : cmp
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		host_u.read(a, v);
		cmp(v, e);
	endtask : rdc
	task automatic wpc(input logic w, input logic f, input logic d0, input logic d1,
		input logic e);
		@(posedge clk);
		wp_n <= w;
		fwp <= f;
		ds0_n <= d0;
		ds1_n <= d1;
		// one cycle of output lag
		repeat (2) @(posedge clk);
		#1;
		cmp({7'h0, wpa}, {7'h0, e});
		cmp({7'h0, fwp_n}, {7'h0, ~e});
	endtask : wpc
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			wrap_up();
		end
	end
	////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(8'h22, 8'h00);
		host_u.write(8'h22, 8'hFD);
		rdc(8'h22, 8'hE9);
		cmp({4'h0, pe}, 8'h00);
		cmp({4'h0, lg | sg}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			host_u.write(8'h22, ob[i]);
			rdc(8'h22, ob[i]);
			cmp({4'h0, pe}, {4'h0, 4'hF ^ (4'h1 << i)});
			cmp({4'h0, sg}, {4'h0, 4'hF ^ (4'h1 << i)});
			cmp({4'h0, lg}, {4'h0, 4'hF ^ (4'h1 << i)});
		end
		$display("override test done");
		host_u.write(8'h22, 8'h01);
		wpc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		host_u.write(8'h22, 8'h00);
		wpc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		wpc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
		wpc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		wpc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		wpc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		wpc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("protect test done");
		@(posedge clk);
		cfg <= 2'h1;
		pin <= 1'b1;
		host_u.write(8'h22, 8'h08);
		rdc(8'h22, 8'h00);
		@(posedge clk);
		pin <= 1'b0;
		host_u.write(8'h22, 8'h08);
		rdc(8'h22, 8'h08);
		@(posedge clk);
		cfg <= 2'h2;
		pin <= 1'b1;
		host_u.write(8'h22, 8'h20);
		rdc(8'h22, 8'h20);
		host_u.write(8'h22, 8'h42);
		rdc(8'h22, 8'h42);
		host_u.write(8'h22, 8'h00);
		rdc(8'h22, 8'h42);
		// status: pin high, locked, first serial off, not writable, no protect
		rdc(8'h2F, 8'hEC);
		cmp({4'h0, pe}, 8'h0B);
		@(posedge clk);
		hrst <= 1'b1;
		@(posedge clk);
		hrst <= 1'b0;
		rdc(8'h22, 8'h00);
		host_u.write(8'h22, 8'h08);
		rdc(8'h22, 8'h08);
		// activate bits decide alone where the override is clear
		@(posedge clk);
		act <= 4'h6;
		lsel <= 4'h3;
		@(posedge clk);
		#1;
		cmp({4'h0, lg}, 8'h02);
		cmp({4'h0, sg}, 8'h06);
		cmp({4'h0, pe}, 8'h06);
		rdc(8'h10, 8'h00);
		$display("lock test done");
		wrap_up();
	end
endmodule : test_peripheral_disable_lock_register
`default_nettype wire
